// *** oufs_cfg.svh ***
// Constants of the output terminal function selector.
// Assumes a single 20 MHz control clock and an AXI4-Lite register port.
`ifndef OUFS_CFG_SVH
`define OUFS_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define OUFS_CLK_HZ         32'h0131_2D00
`define OUFS_MS_PER_S       32'h0000_03E8
`define OUFS_INDEX_HOLD_MS  32'h0000_000A
`define OUFS_INDEX_HOLD_CYC (`OUFS_INDEX_HOLD_MS * (`OUFS_CLK_HZ / `OUFS_MS_PER_S))

// ****************************************
// Geometry
// ****************************************
`define OUFS_NUM_OUT   4
`define OUFS_CODE_W    6
`define OUFS_AW        8
`define OUFS_CARD_W    7
`define OUFS_VT_W      4

// ****************************************
// Output slots
// ****************************************
`define OUFS_IDX_TRANS 0
`define OUFS_IDX_FAST  1
`define OUFS_IDX_RLYA  2
`define OUFS_IDX_RLYB  3

// ****************************************
// Register map and reset values
// ****************************************
`define OUFS_REG_TYPE  3'h0
`define OUFS_REG_STRAN 3'h1
`define OUFS_REG_SFAST 3'h2
`define OUFS_REG_SRLYA 3'h3
`define OUFS_REG_SRLYB 3'h4
`define OUFS_REG_VTERM 3'h5
`define OUFS_REG_STATE 3'h6
`define OUFS_REG_NONE  3'h7
`define OUFS_RST_TYPE  1'h0
`define OUFS_RST_STRAN 6'h00
`define OUFS_RST_SFAST 6'h00
`define OUFS_RST_SRLYA 6'h01
`define OUFS_RST_SRLYB 6'h05
`define OUFS_VT_SERIAL 0
`define OUFS_VT_FIELD  1
`define OUFS_VT_ETH    2
`define OUFS_VT_RT     3
`define OUFS_RESP_OK   2'h0
`define OUFS_RESP_ERR  2'h2

`endif

// *** oufs_pkg.sv ***
// Types of the output terminal function selector.
// Assumes oufs_cfg.svh sits in the include path.
`include "oufs_cfg.svh"

package oufs_pkg;

  // ****************************************
  // Function codes
  // ****************************************
  typedef enum logic [`OUFS_CODE_W-1:0] {
    fn_none = 6'h00, fn_run = 6'h01, fn_fwd = 6'h02, fn_rev = 6'h03,
    fn_jog = 6'h04, fn_fault = 6'h05, fn_fdt_a = 6'h06, fn_fdt_b = 6'h07,
    fn_freq_hit = 6'h08, fn_zero_run = 6'h09, fn_upper = 6'h0a,
    fn_lower = 6'h0b, fn_ready = 6'h0c, fn_preexc = 6'h0d,
    fn_overload = 6'h0e, fn_underload = 6'h0f, fn_plc_stage = 6'h10,
    fn_plc_cycle = 6'h11, fn_set_cnt = 6'h12, fn_desig_cnt = 6'h13,
    fn_ext_fault = 6'h14, fn_run_time = 6'h16, fn_vt_serial = 6'h17,
    fn_vt_field = 6'h18, fn_vt_eth = 6'h19, fn_dc_bus = 6'h1a,
    fn_index = 6'h1b, fn_superpos = 6'h1c, fn_sto = 6'h1d,
    fn_positioned = 6'h1e, fn_spin_zero = 6'h1f, fn_spin_index = 6'h20,
    fn_spd_limit = 6'h21, fn_vt_rt = 6'h22, fn_mode_sw = 6'h24,
    fn_any_freq = 6'h25, fn_card_first = 6'h29, fn_card_last = 6'h2f,
    fn_oh_pt100 = 6'h30, fn_oh_pt1000 = 6'h31, fn_oh_analog = 6'h32,
    fn_stop_zero = 6'h33, fn_breakage = 6'h34, fn_roll_set = 6'h35,
    fn_roll_max = 6'h36, fn_roll_min = 6'h37, fn_fire = 6'h38
  } oufs_func_e;

  // ****************************************
  // Drive core status conditions
  // ****************************************
  typedef struct packed {
    logic running, fwd_running, rev_running, jogging, drive_fault;
    logic freq_level_detect_a, freq_level_detect_b, freq_reached;
    logic zero_speed_run, upper_limit, lower_limit, ready, pre_exciting;
    logic overload_pre, underload_pre, plc_stage_done, plc_cycle_done;
    logic set_count_hit, desig_count_hit, ext_fault, run_time_hit;
    logic dc_bus_ok, encoder_index, superpos_active, safe_torque_off;
    logic positioned, spindle_zeroed, spindle_indexed, speed_limited;
    logic mode_switch_done, ramp_above_detect;
    logic overheat_pt100, overheat_pt1000, overheat_analog, stopped;
    logic breakage, breakage_det_en, tension_running;
    logic roll_set_hit, roll_max_hit, roll_min_hit, fire_mode;
  } oufs_drive_status_s;

  // ****************************************
  // Whole state of the selector
  // ****************************************
  typedef struct packed {
    logic                                    fast_type;
    logic                                    pulse_mode;
    logic [`OUFS_NUM_OUT-1:0][`OUFS_CODE_W-1:0] sel;
    logic [`OUFS_VT_W-1:0]                   vterm;
    logic [`OUFS_NUM_OUT-1:0]                out;
    logic                                    awready;
    logic                                    wready;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic [`OUFS_AW-1:0]                     aw_addr;
    logic [31:0]                             w_data;
    logic [3:0]                              w_strb;
    logic                                    arready;
    logic                                    rvalid;
    logic [31:0]                             rdata;
    logic [1:0]                              rresp;
  } oufs_state_s;

endpackage : oufs_pkg

// *** oufs_index_hold.sv ***
// Stretches each rising edge of the encoder index into a fixed-length level.
// Assumes the index input is synchronous to ref_clk_in.
`timescale 1ns/1ns
`include "oufs_cfg.svh"

module oufs_index_hold #(
  parameter int HOLD_CYCLES = `OUFS_INDEX_HOLD_CYC
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // Pulse in, stretched level out
  input  wire logic index_in,
  output logic      hold_out
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  typedef struct packed {
    logic          prev;
    logic          hold;
    logic [CW-1:0] cnt;
  } oufs_hold_s;

  oufs_hold_s q, d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d      = q;
    d.prev = index_in;
    if (index_in && !q.prev) begin
      // A new edge restarts the full window
      d.hold = 1'b1;
      d.cnt  = CW'(HOLD_CYCLES - 1);
    end else if (q.hold) begin
      if (q.cnt == '0) begin
        d.hold = 1'b0;
      end else begin
        d.cnt = q.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hold_out = q.hold;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  index_rise_a: assert property (
    (index_in && !q.prev) |=> (hold_out && q.cnt == CW'(HOLD_CYCLES - 1)))
    else $error("index edge did not start the hold window");

  index_end_a: assert property (
    (hold_out && q.cnt == '0 && !(index_in && !q.prev)) |=> !hold_out)
    else $error("hold window did not end on time");

endmodule : oufs_index_hold

// *** oufs_top.sv ***
// Output terminal function selector: routes drive conditions to four outputs.
// Assumes synchronous status inputs and an AXI4-Lite master on the register port.
// Operation
// - Code 27: output on encoder index edge, off 10 ms later.
// - Code 28: output while pulse superposition input is active.
// - Code 29: output while a safe torque off fault is present.
// - Code 30: output when positioning has completed.
// - Code 31: output when spindle zero return has completed.
// - Code 32: output when spindle indexing has completed.
// - Code 33: output while frequency is clamped by the speed limit.
// - Code 34: output follows virtual terminal bit 3 (OUFS_VT_RT).
// - Code 36: output when speed/position switchover has completed.
// - Code 37: output while ramp reference exceeds detection value.
// - Codes 41 to 47 pass expansion card outputs unchanged.
// - Codes 48, 49: card PT100 or PT1000 overheat pre-alarm.
// - Code 50: analog channel overheat pre-alarm.
// - Code 51: output when stopped or running at zero speed.
// - Code 52: breakage detected, only when breakage detection enabled.
// - Codes 53 to 55: roll diameter set, max, min while tension running.
// - Code 56: output while fire mode is on.
// - Fast output type: 0 pulse generator, 1 switched output.
// - Own selection per output; reset codes 0, 0, 1, 5.
// - Codes 0 to 5: none, run, forward, reverse, jog, fault.
// - Codes 18, 19 counts, 20 external fault, 22 run time; 21 reserved.
// - The same code may drive several outputs at once.
// - Code 26: output while DC bus is above undervoltage.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "oufs_cfg.svh"

module oufs_top #(
  parameter int INDEX_HOLD_CYCLES = `OUFS_INDEX_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         rst_in,
  // Drive conditions
  input  wire oufs_pkg::oufs_drive_status_s status_in,
  input  wire logic [`OUFS_CARD_W-1:0]      card_out_in,
  // Terminal outputs
  output logic                              transistor_out_a_out,
  output logic                              fast_out_out,
  output logic                              relay_out_a_out,
  output logic                              relay_out_b_out,
  output logic                              fast_pulse_mode_out,
  // AXI4-Lite write
  input  wire logic [`OUFS_AW-1:0]          s_axi_awaddr_in,
  input  wire logic                         s_axi_awvalid_in,
  output logic                              s_axi_awready_out,
  input  wire logic [31:0]                  s_axi_wdata_in,
  input  wire logic [3:0]                   s_axi_wstrb_in,
  input  wire logic                         s_axi_wvalid_in,
  output logic                              s_axi_wready_out,
  output logic [1:0]                        s_axi_bresp_out,
  output logic                              s_axi_bvalid_out,
  input  wire logic                         s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [`OUFS_AW-1:0]          s_axi_araddr_in,
  input  wire logic                         s_axi_arvalid_in,
  output logic                              s_axi_arready_out,
  output logic [31:0]                       s_axi_rdata_out,
  output logic [1:0]                        s_axi_rresp_out,
  output logic                              s_axi_rvalid_out,
  input  wire logic                         s_axi_rready_in
);

  // ****************************************
  // Functions
  // ****************************************
  // Word offset to register slot; misaligned or unknown gives none
  function automatic logic [2:0] oufs_map(input logic [`OUFS_AW-1:0] addr);
    logic [2:0] idx;
    idx = `OUFS_REG_NONE;
    if (addr[1:0] == 2'h0 && addr[`OUFS_AW-1:2] < `OUFS_AW'(`OUFS_REG_NONE)) begin
      idx = addr[4:2];
    end
    return idx;
  endfunction : oufs_map

  // One condition bit per selection code
  function automatic logic [63:0] oufs_conds(
    input oufs_pkg::oufs_drive_status_s s,
    input logic [`OUFS_CARD_W-1:0]      card,
    input logic [`OUFS_VT_W-1:0]        vt,
    input logic                         idx_hold
  );
    logic [63:0] v;
    v = '0;
    v[oufs_pkg::fn_run]        = s.running;
    v[oufs_pkg::fn_fwd]        = s.fwd_running;
    v[oufs_pkg::fn_rev]        = s.rev_running;
    v[oufs_pkg::fn_jog]        = s.jogging;
    v[oufs_pkg::fn_fault]      = s.drive_fault;
    v[oufs_pkg::fn_fdt_a]      = s.freq_level_detect_a;
    v[oufs_pkg::fn_fdt_b]      = s.freq_level_detect_b;
    v[oufs_pkg::fn_freq_hit]   = s.freq_reached;
    v[oufs_pkg::fn_zero_run]   = s.zero_speed_run;
    v[oufs_pkg::fn_upper]      = s.upper_limit;
    v[oufs_pkg::fn_lower]      = s.lower_limit;
    v[oufs_pkg::fn_ready]      = s.ready;
    v[oufs_pkg::fn_preexc]     = s.pre_exciting;
    v[oufs_pkg::fn_overload]   = s.overload_pre;
    v[oufs_pkg::fn_underload]  = s.underload_pre;
    v[oufs_pkg::fn_plc_stage]  = s.plc_stage_done;
    v[oufs_pkg::fn_plc_cycle]  = s.plc_cycle_done;
    v[oufs_pkg::fn_set_cnt]    = s.set_count_hit;
    v[oufs_pkg::fn_desig_cnt]  = s.desig_count_hit;
    v[oufs_pkg::fn_ext_fault]  = s.ext_fault;
    v[oufs_pkg::fn_run_time]   = s.run_time_hit;
    v[oufs_pkg::fn_vt_serial]  = vt[`OUFS_VT_SERIAL];
    v[oufs_pkg::fn_vt_field]   = vt[`OUFS_VT_FIELD];
    v[oufs_pkg::fn_vt_eth]     = vt[`OUFS_VT_ETH];
    v[oufs_pkg::fn_dc_bus]     = s.dc_bus_ok;
    v[oufs_pkg::fn_index]      = idx_hold;
    v[oufs_pkg::fn_superpos]   = s.superpos_active;
    v[oufs_pkg::fn_sto]        = s.safe_torque_off;
    v[oufs_pkg::fn_positioned] = s.positioned;
    v[oufs_pkg::fn_spin_zero]  = s.spindle_zeroed;
    v[oufs_pkg::fn_spin_index] = s.spindle_indexed;
    v[oufs_pkg::fn_spd_limit]  = s.speed_limited;
    v[oufs_pkg::fn_vt_rt]      = vt[`OUFS_VT_RT];
    v[oufs_pkg::fn_mode_sw]    = s.mode_switch_done;
    v[oufs_pkg::fn_any_freq]   = s.ramp_above_detect;
    v[oufs_pkg::fn_card_last:oufs_pkg::fn_card_first] = card;
    v[oufs_pkg::fn_oh_pt100]   = s.overheat_pt100;
    v[oufs_pkg::fn_oh_pt1000]  = s.overheat_pt1000;
    v[oufs_pkg::fn_oh_analog]  = s.overheat_analog;
    v[oufs_pkg::fn_stop_zero]  = s.stopped | s.zero_speed_run;
    v[oufs_pkg::fn_breakage]   = s.breakage & s.breakage_det_en;
    v[oufs_pkg::fn_roll_set]   = s.roll_set_hit & s.tension_running;
    v[oufs_pkg::fn_roll_max]   = s.roll_max_hit & s.tension_running;
    v[oufs_pkg::fn_roll_min]   = s.roll_min_hit & s.tension_running;
    v[oufs_pkg::fn_fire]       = s.fire_mode;
    return v;
  endfunction : oufs_conds

  // ****************************************
  // State and reset value
  // ****************************************
  localparam oufs_pkg::oufs_state_s ST_RST = '{
    fast_type:  `OUFS_RST_TYPE,
    pulse_mode: 1'b1,
    sel:        {`OUFS_RST_SRLYB, `OUFS_RST_SRLYA, `OUFS_RST_SFAST, `OUFS_RST_STRAN},
    awready:    1'b1,
    wready:     1'b1,
    arready:    1'b1,
    default:    '0
  };

  oufs_pkg::oufs_state_s q, d;
  logic                  index_hold;
  logic [63:0]           conds;
  logic [2:0]            wr_idx;
  logic [2:0]            rd_idx;

  oufs_index_hold #(
    .HOLD_CYCLES (INDEX_HOLD_CYCLES)
  ) oufs_index_hold_i (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .index_in   (status_in.encoder_index),
    .hold_out   (index_hold)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d      = q;
    conds  = oufs_conds(status_in, card_out_in, q.vterm, index_hold);
    wr_idx = oufs_map(q.aw_addr);
    rd_idx = oufs_map(s_axi_araddr_in);
    // Registering the pick keeps a code change from glitching a relay
    for (int i = 0; i < `OUFS_NUM_OUT; i++) begin
      d.out[i] = conds[q.sel[i]];
    end
    // Pulse mode leaves the pin to the external pulse generator
    d.out[`OUFS_IDX_FAST] = q.fast_type & conds[q.sel[`OUFS_IDX_FAST]];
    d.pulse_mode          = ~q.fast_type;

    // Write address and data are taken independently
    if (q.awready && s_axi_awvalid_in) begin
      d.awready = 1'b0;
      d.aw_addr = s_axi_awaddr_in;
    end
    if (q.wready && s_axi_wvalid_in) begin
      d.wready = 1'b0;
      d.w_data = s_axi_wdata_in;
      d.w_strb = s_axi_wstrb_in;
    end
    if (!q.awready && !q.wready && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp  = (wr_idx == `OUFS_REG_NONE) ? `OUFS_RESP_ERR : `OUFS_RESP_OK;
      // Fields are narrow, only the low byte lane matters
      if (q.w_strb[0]) begin
        case (wr_idx)
          `OUFS_REG_TYPE:  d.fast_type = q.w_data[0];
          `OUFS_REG_STRAN: d.sel[`OUFS_IDX_TRANS] = q.w_data[5:0];
          `OUFS_REG_SFAST: d.sel[`OUFS_IDX_FAST] = q.w_data[5:0];
          `OUFS_REG_SRLYA: d.sel[`OUFS_IDX_RLYA] = q.w_data[5:0];
          `OUFS_REG_SRLYB: d.sel[`OUFS_IDX_RLYB] = q.w_data[5:0];
          `OUFS_REG_VTERM: d.vterm = q.w_data[`OUFS_VT_W-1:0];
          default: ;
        endcase
      end
    end
    if (q.bvalid && s_axi_bready_in) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end

    // Reads answer one cycle after the address is taken
    if (q.arready && s_axi_arvalid_in) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = (rd_idx == `OUFS_REG_NONE) ? `OUFS_RESP_ERR : `OUFS_RESP_OK;
      case (rd_idx)
        `OUFS_REG_TYPE:  d.rdata = {31'h0000_0000, q.fast_type};
        `OUFS_REG_STRAN: d.rdata = {26'h000_0000, q.sel[`OUFS_IDX_TRANS]};
        `OUFS_REG_SFAST: d.rdata = {26'h000_0000, q.sel[`OUFS_IDX_FAST]};
        `OUFS_REG_SRLYA: d.rdata = {26'h000_0000, q.sel[`OUFS_IDX_RLYA]};
        `OUFS_REG_SRLYB: d.rdata = {26'h000_0000, q.sel[`OUFS_IDX_RLYB]};
        `OUFS_REG_VTERM: d.rdata = {28'h000_0000, q.vterm};
        `OUFS_REG_STATE: d.rdata = {27'h000_0000, q.pulse_mode, q.out};
        default:         d.rdata = 32'h0000_0000;
      endcase
    end
    if (q.rvalid && s_axi_rready_in) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign transistor_out_a_out = q.out[`OUFS_IDX_TRANS];
  assign fast_out_out         = q.out[`OUFS_IDX_FAST];
  assign relay_out_a_out      = q.out[`OUFS_IDX_RLYA];
  assign relay_out_b_out      = q.out[`OUFS_IDX_RLYB];
  assign fast_pulse_mode_out  = q.pulse_mode;
  assign s_axi_awready_out    = q.awready;
  assign s_axi_wready_out     = q.wready;
  assign s_axi_bvalid_out     = q.bvalid;
  assign s_axi_bresp_out      = q.bresp;
  assign s_axi_arready_out    = q.arready;
  assign s_axi_rvalid_out     = q.rvalid;
  assign s_axi_rdata_out      = q.rdata;
  assign s_axi_rresp_out      = q.rresp;

  // ****************************************
  // Checks
  // ****************************************
  logic card_pick;
  assign card_pick = card_out_in[3'(q.sel[`OUFS_IDX_TRANS] - oufs_pkg::fn_card_first)];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  stop_zero_a: assert property (
    (q.sel[`OUFS_IDX_TRANS] == oufs_pkg::fn_stop_zero
      && (status_in.stopped || status_in.zero_speed_run)) |=> transistor_out_a_out)
    else $error("stopped or zero speed not shown");

  sto_fault_a: assert property (
    (q.sel[`OUFS_IDX_RLYA] == oufs_pkg::fn_sto) |=>
      (relay_out_a_out == $past(status_in.safe_torque_off)))
    else $error("relay a does not follow torque off fault");

  reserved_off_a: assert property (
    (q.sel[`OUFS_IDX_RLYB] > oufs_pkg::fn_fire) |=> !relay_out_b_out)
    else $error("reserved code drove relay b");

  card_pass_a: assert property (
    (q.sel[`OUFS_IDX_TRANS] >= oufs_pkg::fn_card_first
      && q.sel[`OUFS_IDX_TRANS] <= oufs_pkg::fn_card_last) |=>
      (transistor_out_a_out == $past(card_pick)))
    else $error("card output not passed through");

  break_gate_a: assert property (
    (q.sel[`OUFS_IDX_RLYA] == oufs_pkg::fn_breakage && !status_in.breakage_det_en)
      |=> !relay_out_a_out)
    else $error("breakage shown while detection disabled");

  roll_run_a: assert property (
    (q.sel[`OUFS_IDX_RLYB] == oufs_pkg::fn_roll_max && !status_in.tension_running)
      |=> !relay_out_b_out)
    else $error("roll diameter shown outside tension running");

  vterm_follow_a: assert property (
    (q.sel[`OUFS_IDX_FAST] == oufs_pkg::fn_vt_rt && q.fast_type) |=>
      (fast_out_out == $past(q.vterm[`OUFS_VT_RT])))
    else $error("fast output does not follow virtual terminal");

  fast_pulse_a: assert property (
    (!q.fast_type) |=> (!fast_out_out && fast_pulse_mode_out))
    else $error("fast output switched in pulse mode");

  same_code_a: assert property (
    (q.sel[`OUFS_IDX_TRANS] == q.sel[`OUFS_IDX_RLYA]) |=>
      (transistor_out_a_out == relay_out_a_out))
    else $error("shared code gave different outputs");

  bresp_hold_a: assert property (
    (s_axi_bvalid_out && !s_axi_bready_in) |=> (s_axi_bvalid_out && $stable(s_axi_bresp_out)))
    else $error("write response dropped before taken");

  card_cov_c: cover property (
    q.sel[`OUFS_IDX_TRANS] == oufs_pkg::fn_card_first ##1 transistor_out_a_out);
  index_cov_c: cover property (
    q.sel[`OUFS_IDX_RLYA] == oufs_pkg::fn_index && relay_out_a_out);
  write_cov_c: cover property (s_axi_bvalid_out && s_axi_bready_in);
  read_cov_c: cover property (s_axi_rvalid_out && s_axi_rready_in);

endmodule : oufs_top

// *** oufs_load_model.sv ***
// Indicator load model hanging on the four terminal outputs.
// Assumes the outputs are registered levels on ref_clk_in.
`timescale 1ns/1ns
module oufs_load_model (
  // Clock
  input  wire logic       ref_clk_in,
  // Terminal levels in, lamp state out
  input  wire logic [3:0] term_in,
  output logic      [3:0] lamp_out
);
  // Lamps lag one cycle, like a slow load
  always_ff @(posedge ref_clk_in) begin
    lamp_out <= term_in;
  end
endmodule : oufs_load_model

// *** output_terminal_function_select_bench.sv ***
// Self-checking bench of the output selector over its AXI4-Lite port.
// Assumes oufs_cfg.svh and oufs_pkg are compiled first.
`timescale 1ns/1ns
module output_terminal_function_select_bench;
  logic clk, rst, awv, wv, bre, arv, rre, aw_rdy, w_rdy, bv, ar_rdy, rv;
  logic o_t, o_f, o_a, o_b, pm;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, got;
  logic [1:0]  br, rr, resp;
  logic [6:0]  card;
  logic [3:0]  lamp;
  oufs_pkg::oufs_drive_status_s st;
  int fails, tests_run, i;
  int code_t[23] = '{1,2,3,4,5,18,19,20,22,26,28,29,30,31,32,33,36,37,48,49,50,51,56};
  int pos_t[23] = '{0,1,2,3,4,17,18,19,20,21,23,24,25,26,27,28,29,30,31,32,33,34,41};
  int rsv_t[12] = '{21,35,38,39,40,57,58,59,60,61,62,63};
  int rst_t[4] = '{0,0,1,5};

  oufs_top #(.INDEX_HOLD_CYCLES(16)) oufs_top_i (.ref_clk_in(clk), .rst_in(rst),
    .status_in(st), .card_out_in(card), .transistor_out_a_out(o_t), .fast_out_out(o_f),
    .relay_out_a_out(o_a), .relay_out_b_out(o_b), .fast_pulse_mode_out(pm),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(aw_rdy),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(w_rdy),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(ar_rdy),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre));
  oufs_load_model oufs_load_model_i (.ref_clk_in(clk), .term_in({o_b, o_a, o_f, o_t}),
    .lamp_out(lamp));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    int n;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    for (n = 0; n < 50; n++) begin
      #1; ra = aw_rdy; rw = w_rdy; rb = bv; resp = br;
      @(posedge clk);
      if (ra) awv <= 1'b0;
      if (rw) wv <= 1'b0;
      if (rb) begin bre <= 1'b0; break; end
    end
    if (n == 50) fails++;
  endtask : wr
  task rdr(input logic [7:0] a);
    logic ra, rb;
    int n;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    for (n = 0; n < 50; n++) begin
      #1; ra = ar_rdy; rb = rv; got = rdat; resp = rr;
      @(posedge clk);
      if (ra) arv <= 1'b0;
      if (rb) begin rre <= 1'b0; break; end
    end
    if (n == 50) fails++;
  endtask : rdr
  task setst(input int p, input logic v);
    @(posedge clk);
    st[41-p] <= v;
    tick(1);
  endtask : setst
  // Same code on all four selections, so every output is exercised
  task wsel(input int c);
    wr(8'h04, 32'(c));
    wr(8'h08, 32'(c));
    wr(8'h0C, 32'(c));
    wr(8'h10, 32'(c));
  endtask : wsel
  task stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // ****************************************
  // Clock, watchdog and scenarios
  // ****************************************
  initial begin clk = 1'b0; forever #25 clk = ~clk; end
  initial begin repeat (40000) @(posedge clk); fails++; stop_test(); end
  initial begin
    rst = 1'b1; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; awa = 0; ara = 0; wd = 0;
    st = '0; card = '0; fails = 0; tests_run = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) begin
      rdr(8'(4 * i));
      check(got, (i == 0) ? 0 : rst_t[i-1]);
    end
    rdr(8'h1C); check(resp, 2);
    wr(8'h1C, 1); check(resp, 2);
    check(pm, 1);
    wr(8'h08, 1); check(resp, 0);
    setst(0, 1);
    check({o_b, o_a, o_f, o_t}, 4'b0100);
    tick(1); check(lamp, 4'b0100);
    setst(0, 0); wr(8'h00, 1); tick(1); check(pm, 0);
    for (i = 0; i < 23; i++) begin
      wsel(code_t[i]);
      setst(pos_t[i], 1);
      check({o_b, o_a, o_f, o_t}, 4'b1111);
      setst(pos_t[i], 0);
      check({o_b, o_a, o_f, o_t}, 4'b0000);
    end
    for (i = 0; i < 7; i++) begin
      wsel(41 + i);
      @(posedge clk); card <= ~(7'h01 << i); tick(1); check(o_t, 0);
      @(posedge clk); card <= 7'h01 << i; tick(1); check(o_t, 1);
    end
    wsel(34); wr(8'h14, 7); tick(1); check(o_t, 0);
    wr(8'h14, 8); tick(1); check(o_t, 1);
    wsel(52); setst(35, 1); check(o_t, 0);
    setst(36, 1); check(o_t, 1);
    for (i = 0; i < 3; i++) begin
      wsel(53 + i); setst(38 + i, 1); check(o_t, 0);
      setst(37, 1); check(o_t, 1);
      setst(37, 0); setst(38 + i, 0);
    end
    @(posedge clk); st <= '1; card <= '1;
    wr(8'h14, 15);
    for (i = 0; i < 12; i++) begin
      wsel(rsv_t[i]); tick(1); check({o_b, o_a, o_f, o_t}, 4'b0000);
    end
    @(posedge clk); st <= '0; card <= '0;
    wsel(27); tick(2); setst(22, 1); tick(1); check(o_t, 1);
    setst(22, 0); tick(10); check(o_t, 1);
    tick(10); check(o_t, 0);
    stop_test();
  end
endmodule : output_terminal_function_select_bench
